/* File: design/fts_sram_host.sv */
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module fts_sram_host import fts_pkg::*; (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   fts_bus_if.host BUS,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   fts_host_st_t state_r, state_nxt;
   logic [1:0] beat_r, beat_nxt;
   logic [7:0] tmr_r, tmr_nxt;
   logic wr_r, burst_r, linear_r, sleep_r, done_r;
   logic [1:0] lanes_r;
   logic [FTS_AW-1:0] addr_r;
   logic [FTS_DW-1:0] buf_r [FTS_LANES*2];
   // ----------------------------------------
   // register decode
   // ----------------------------------------
   wire sel_ctrl = REG_ADDR == FTS_REG_CTRL;
   wire sel_addr = REG_ADDR == FTS_REG_ADDR;
   wire sel_stat = REG_ADDR == FTS_REG_STATUS;
   wire sel_data = REG_ADDR[7:4] == FTS_REG_DATA_PAGE && REG_ADDR[1:0] == 2'h0;
   wire [1:0] data_idx = REG_ADDR[3:2];
   wire idle = state_r == FTS_IDLE;
   // go is dropped unless idle; software polls busy first
   wire go = REG_WR & sel_ctrl & REG_WDATA[FTS_CTRL_GO] & ~REG_WDATA[FTS_CTRL_SLEEP] & idle;
   wire in_burst = state_r == FTS_BURST;
   wire starting = state_r == FTS_START;
   wire last_beat = beat_r == FTS_CNT_LAST || !burst_r;
   wire capture = in_burst & ~wr_r;
   wire writing = wr_r & (starting | in_burst);
   wire [FTS_ST_W-1:0] status = {done_r, state_r == FTS_WAKE,
                                 state_r == FTS_ASLEEP || state_r == FTS_ENTER, ~idle};
   wire [31:0] rd_mux = sel_ctrl ? 32'({lanes_r, linear_r, sleep_r, burst_r, wr_r, 1'b0}) :
                        sel_addr ? 32'(addr_r) :
                        sel_stat ? 32'(status) :
                        sel_data ? 32'(buf_r[data_idx]) : 32'h0000_0000;
   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      beat_nxt = beat_r;
      tmr_nxt = tmr_r;
      case (state_r)
         FTS_IDLE: begin
            if (go) begin
               state_nxt = FTS_START;
            end else if (sleep_r) begin
               state_nxt = FTS_ENTER; // only from idle, nothing in flight
               tmr_nxt = FTS_ENTRY_CYC;
            end
         end
         FTS_START: begin
            beat_nxt = wr_r ? FTS_CNT_ONE : FTS_CNT_ZERO;
            state_nxt = (wr_r && !burst_r) ? FTS_IDLE : FTS_BURST;
         end
         FTS_BURST: begin
            beat_nxt = 2'(beat_r + FTS_CNT_ONE);
            if (last_beat) begin
               state_nxt = FTS_IDLE;
            end
         end
         FTS_ENTER: begin
            tmr_nxt = 8'(tmr_r - FTS_TMR_DONE);
            if (tmr_r == FTS_TMR_DONE) begin
               state_nxt = FTS_ASLEEP;
            end
         end
         FTS_ASLEEP: begin
            if (!sleep_r) begin
               state_nxt = FTS_WAKE;
               tmr_nxt = FTS_EXIT_CYC;
            end
         end
         FTS_WAKE: begin
            // only deselects while waking
            tmr_nxt = 8'(tmr_r - FTS_TMR_DONE);
            if (tmr_r == FTS_TMR_DONE) begin
               state_nxt = FTS_IDLE;
            end
         end
         default: state_nxt = FTS_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         state_r <= FTS_IDLE;
         beat_r <= FTS_CNT_ZERO;
         tmr_r <= 8'h00;
         wr_r <= 1'b0;
         burst_r <= 1'b0;
         linear_r <= 1'b0;
         sleep_r <= 1'b0;
         lanes_r <= FTS_LANES_ALL;
         addr_r <= '0;
         done_r <= 1'b0;
         REG_RDATA <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         beat_r <= beat_nxt;
         tmr_r <= tmr_nxt;
         REG_RDATA <= REG_RD ? rd_mux : 32'h0000_0000;
         if (REG_WR && sel_ctrl) begin
            sleep_r <= REG_WDATA[FTS_CTRL_SLEEP];
         end
         if (go) begin
            wr_r <= REG_WDATA[FTS_CTRL_WR];
            burst_r <= REG_WDATA[FTS_CTRL_BURST];
            linear_r <= REG_WDATA[FTS_CTRL_LINEAR];
            lanes_r <= REG_WDATA[FTS_CTRL_LANE_LO +: 2];
         end
         if (REG_WR && sel_addr && idle) begin
            addr_r <= REG_WDATA[FTS_AW-1:0];
         end
         if (in_burst && last_beat || starting && wr_r && !burst_r) begin
            done_r <= 1'b1;
         end else if (go) begin
            done_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (capture) begin
         buf_r[beat_r] <= BUS.dq;
      end else if (REG_WR && sel_data) begin
         buf_r[data_idx] <= REG_WDATA[FTS_DW-1:0];
      end
   end
   // ----------------------------------------
   // pins
   // ----------------------------------------
   // controller strobe with processor strobe held high
   assign BUS.proc_addr_strobe_n = 1'b1;
   assign BUS.ctrl_addr_strobe_n = ~starting;
   assign BUS.master_select_n = ~starting;
   assign BUS.chip_sel_hi = 1'b1;
   assign BUS.chip_sel_lo_n = 1'b0;
   assign BUS.addr = addr_r;
   assign BUS.burst_step_n = ~(in_burst & (wr_r | ~last_beat));
   assign BUS.all_bytes_write_n = ~(writing & (lanes_r == FTS_LANES_ALL || lanes_r == FTS_LANES_NONE));
   assign BUS.byte_write_gate_n = ~writing;
   assign BUS.lane0_write_n = ~(writing & lanes_r[0]);
   assign BUS.lane1_write_n = ~(writing & lanes_r[1]);
   // outputs only enabled in read beats; idle gap precedes any write
   assign BUS.oe_n = ~capture;
   assign BUS.burst_order_sel = ~linear_r;
   assign BUS.sleep_request = state_r == FTS_ENTER || state_r == FTS_ASLEEP;
   assign BUS.host_dq_oe = writing;
   assign BUS.host_dq_o = starting ? buf_r[0] : buf_r[beat_r];
endmodule // fts_sram_host

/* File: inc/fts_pkg.sv */
// ----------------------------------------
// shared constants
// ----------------------------------------
package fts_pkg;
   localparam int FTS_AW = 18;
   localparam int FTS_DW = 18;
   localparam int FTS_LW = 9;
   localparam int FTS_LANES = 2;
   localparam int FTS_DEPTH = 262144;
   localparam logic [1:0] FTS_CNT_ZERO = 2'h0;
   localparam logic [1:0] FTS_CNT_ONE = 2'h1;
   localparam logic [1:0] FTS_CNT_LAST = 2'h3;
   localparam logic [1:0] FTS_LANES_ALL = 2'h3;
   localparam logic [1:0] FTS_LANES_NONE = 2'h0;
   // ----------------------------------------
   // controller register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] FTS_REG_CTRL = 8'h00;
   localparam logic [7:0] FTS_REG_ADDR = 8'h04;
   localparam logic [7:0] FTS_REG_STATUS = 8'h08;
   localparam logic [3:0] FTS_REG_DATA_PAGE = 4'h1;
   localparam int FTS_CTRL_GO = 0;
   localparam int FTS_CTRL_WR = 1;
   localparam int FTS_CTRL_BURST = 2;
   localparam int FTS_CTRL_SLEEP = 3;
   localparam int FTS_CTRL_LINEAR = 4;
   localparam int FTS_CTRL_LANE_LO = 5;
   localparam int FTS_ST_W = 4;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int FTS_CLK_NS = 4;
   localparam int FTS_SLEEP_ENTRY_NS = 20;
   localparam int FTS_SLEEP_EXIT_NS = 40;
   localparam logic [7:0] FTS_ENTRY_CYC = 8'((FTS_SLEEP_ENTRY_NS + FTS_CLK_NS - 1) / FTS_CLK_NS);
   localparam logic [7:0] FTS_EXIT_CYC = 8'((FTS_SLEEP_EXIT_NS + FTS_CLK_NS - 1) / FTS_CLK_NS);
   localparam logic [7:0] FTS_TMR_DONE = 8'h01;
   typedef enum logic [2:0] {
      FTS_IDLE = 3'b000,
      FTS_START = 3'b001,
      FTS_BURST = 3'b010,
      FTS_ENTER = 3'b011,
      FTS_ASLEEP = 3'b100,
      FTS_WAKE = 3'b101
   } fts_host_st_t;
endpackage

/* File: inc/fts_bus_if.sv */
`timescale 1ns/1ns
// ----------------------------------------
// synchronous burst sram pins
// ----------------------------------------
interface fts_bus_if import fts_pkg::*; ();
   logic [FTS_AW-1:0] addr;
   logic master_select_n;
   logic chip_sel_hi;
   logic chip_sel_lo_n;
   logic proc_addr_strobe_n;
   logic ctrl_addr_strobe_n;
   logic burst_step_n;
   logic all_bytes_write_n;
   logic byte_write_gate_n;
   logic lane0_write_n;
   logic lane1_write_n;
   logic oe_n;
   logic burst_order_sel;
   logic sleep_request;
   logic [FTS_DW-1:0] host_dq_o;
   logic host_dq_oe;
   logic [FTS_DW-1:0] dev_dq_o;
   logic dev_dq_oe;
   logic [FTS_DW-1:0] dq;
   // shared data wire; undriven bus reads as pulled high
   assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : {FTS_DW{1'b1}});
   modport dev (
      input addr, master_select_n, chip_sel_hi, chip_sel_lo_n, proc_addr_strobe_n,
      input ctrl_addr_strobe_n, burst_step_n, all_bytes_write_n, byte_write_gate_n,
      input lane0_write_n, lane1_write_n, oe_n, burst_order_sel, sleep_request, dq,
      output dev_dq_o, dev_dq_oe
   );
   modport host (
      output addr, master_select_n, chip_sel_hi, chip_sel_lo_n, proc_addr_strobe_n,
      output ctrl_addr_strobe_n, burst_step_n, all_bytes_write_n, byte_write_gate_n,
      output lane0_write_n, lane1_write_n, oe_n, burst_order_sel, sleep_request,
      output host_dq_o, host_dq_oe,
      input dq
   );
endinterface // fts_bus_if

/* File: design/fts_sram_dev.sv */
`timescale 1ns/1ns
// Operation
// - sample inputs on clock, three asynchronous exceptions
// - capture address when selected and strobed
// - drive data only when selected, enabled
// - master select gates processor strobe
// - second select high, third low
// - strobe loads address or deselects
// - step low advances the burst
// - global write writes all eighteen bits
// - byte gate low: lane low writes
// - per lane write decode
// - output enable acts asynchronously on reads
// - order select high interleaved, low linear
// - four beat burst, xor or increment
// - sleep request deselects while high
// - sleep ignores inputs, outputs off, data kept
// - far end sleeps only when idle
// - far end deselects or reads while waking
// - sleep request defaults low
// - far end disables outputs before writing
// - step ignored on processor strobe edge
// - controller start needs processor strobe high
// - sampled lane write disables drivers
module fts_sram_dev import fts_pkg::*; (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   fts_bus_if.dev BUS,
   output logic BURST_ACTIVE,
   output logic SLEEPING,
   output logic READ_MODE
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   // one word per address in two nine-bit lanes; no reset, so no clear loop
   logic [FTS_DW-1:0] mem [FTS_DEPTH];

   // ----------------------------------------
   // burst state
   // ----------------------------------------
   logic active_r;
   logic active_nxt;
   logic read_r;
   logic read_nxt;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic [1:0] start_r;
   logic [1:0] start_nxt;
   logic [FTS_AW-3:0] upper_r;
   logic [FTS_AW-3:0] upper_nxt;

   // ----------------------------------------
   // asynchronous and static inputs
   // ----------------------------------------
   // sleep and order act at once, without waiting for a clock edge
   // unconnected sleep pin is modelled as low: only a driven high puts the part to sleep
   wire asleep = BUS.sleep_request === 1'b1;
   // undriven order pin reads as interleaved
   wire linear = BUS.burst_order_sel === 1'b0;

   // ----------------------------------------
   // strobe and select decode
   // ----------------------------------------
   // raw strobe levels, turned active high
   wire proc_low = ~BUS.proc_addr_strobe_n;
   wire ctrl_low = ~BUS.ctrl_addr_strobe_n;
   // master select blocks the processor strobe
   wire proc_eff_n = ~proc_low | BUS.master_select_n;
   wire proc_take = ~proc_eff_n & ~asleep;
   // controller start only with processor strobe seen high
   wire ctrl_take = ctrl_low & proc_eff_n & ~asleep;
   wire strobe = proc_take | ctrl_take;
   // three selects, each turned active high
   wire sel_master = ~BUS.master_select_n;
   wire sel_hi = BUS.chip_sel_hi;
   wire sel_lo = ~BUS.chip_sel_lo_n;
   // selects only matter on a strobe edge; between strobes they are ignored
   wire selected = sel_master & sel_hi & sel_lo;
   wire load = strobe & selected;
   wire desel = strobe & ~selected;
   // no strobe: an open burst continues or is suspended
   wire cont = ~asleep & ~strobe & active_r;
   // step is never seen on a start edge
   wire step = cont & ~BUS.burst_step_n;

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   wire glob_wr = ~BUS.all_bytes_write_n;
   wire gate_wr = ~BUS.byte_write_gate_n;
   wire [1:0] lane_req = {~BUS.lane1_write_n, ~BUS.lane0_write_n};
   // lane pins count only behind the byte gate; gate high is a read unless the global write is low
   wire [1:0] gate_lanes = gate_wr ? lane_req : FTS_LANES_NONE;
   // global write overrides the lane pins
   wire [1:0] lane_dec = glob_wr ? FTS_LANES_ALL : gate_lanes;
   // writes are not taken on a processor strobe edge
   wire ctrl_start = ctrl_take & selected;
   wire wr_window = ctrl_start | cont;
   wire [1:0] wr_lanes = wr_window ? lane_dec : FTS_LANES_NONE;
   wire wr_any = |wr_lanes;

   // ----------------------------------------
   // burst address generation
   // ----------------------------------------
   // four-beat counter; wraps back to the start value
   wire [1:0] cnt_inc = 2'(cnt_r + FTS_CNT_ONE);

   always_comb begin
      cnt_nxt = cnt_r;
      start_nxt = start_r;
      upper_nxt = upper_r;
      if (load) begin
         cnt_nxt = FTS_CNT_ZERO;
         start_nxt = BUS.addr[1:0];
         upper_nxt = BUS.addr[FTS_AW-1:2];
      end else if (step) begin
         cnt_nxt = cnt_inc;
      end
   end

   // low bits only; upper bits are frozen for the burst
   // both orders are formed; the static order pin picks one
   wire [1:0] acc_lin = 2'(start_nxt + cnt_nxt);
   wire [1:0] acc_ilv = start_nxt ^ cnt_nxt;
   wire [1:0] acc_lo = linear ? acc_lin : acc_ilv;
   wire [FTS_AW-1:0] acc_addr = {upper_nxt, acc_lo};
   wire [1:0] cur_lin = 2'(start_r + cnt_r);
   wire [1:0] cur_ilv = start_r ^ cnt_r;
   wire [1:0] cur_lo = linear ? cur_lin : cur_ilv;
   wire [FTS_AW-1:0] cur_addr = {upper_r, cur_lo};

   // ----------------------------------------
   // cycle state
   // ----------------------------------------
   // a write beat keeps the drivers off in the cycle after it
   wire read_beat = ~wr_any;

   always_comb begin
      active_nxt = active_r;
      read_nxt = read_r;
      if (asleep) begin
         active_nxt = 1'b0;
         read_nxt = 1'b0;
      end else if (load) begin
         active_nxt = 1'b1;
         read_nxt = read_beat;
      end else if (desel) begin
         active_nxt = 1'b0;
         read_nxt = 1'b0;
      end else if (cont) begin
         read_nxt = read_beat;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         active_r <= 1'b0;
         read_r <= 1'b0;
      end else begin
         active_r <= active_nxt;
         read_r <= read_nxt;
      end
   end

   // address state is left alone by sleep; only the burst and read flags are dropped
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         cnt_r <= FTS_CNT_ZERO;
         start_r <= FTS_CNT_ZERO;
         upper_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         start_r <= start_nxt;
         upper_r <= upper_nxt;
      end
   end

   // ----------------------------------------
   // array write, per lane
   // ----------------------------------------
   // array is not cleared by reset or sleep; contents survive
   always_ff @(posedge REF_CLK) begin
      for (int i = 0; i < FTS_LANES; i++) begin
         if (!SYS_RST && wr_lanes[i]) begin
            mem[acc_addr][i*FTS_LW +: FTS_LW] <= BUS.dq[i*FTS_LW +: FTS_LW];
         end
      end
   end

   // ----------------------------------------
   // data out
   // ----------------------------------------
   // flow-through: the array feeds the pins directly, trading
   // clock-to-data time for one cycle less latency
   assign BUS.dev_dq_o = mem[cur_addr];
   // read mode and selection are sampled; the enable pin is not
   wire drive_ok = active_r & read_r;
   // enable is combinational in the output enable pin
   assign BUS.dev_dq_oe = drive_ok & ~BUS.oe_n & ~asleep;

   // ----------------------------------------
   // user side status
   // ----------------------------------------
   // user-side view only; nothing on the memory bus depends on these
   assign BURST_ACTIVE = active_r;
   assign SLEEPING = asleep;
   assign READ_MODE = read_r;
endmodule // fts_sram_dev

/* File: verification/fts_bus_properties.sv */
`timescale 1ns/1ns
module fts_bus_properties (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic master_select_n,
   input wire logic chip_sel_hi,
   input wire logic chip_sel_lo_n,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_step_n,
   input wire logic all_bytes_write_n,
   input wire logic byte_write_gate_n,
   input wire logic lane0_write_n,
   input wire logic lane1_write_n,
   input wire logic oe_n,
   input wire logic burst_order_sel,
   input wire logic sleep_request,
   input wire logic host_dq_oe,
   input wire logic dev_dq_oe
);
   // ----------------------------------------
   // decoded bus cycles
   // ----------------------------------------
   wire sel_w = !master_select_n && chip_sel_hi && !chip_sel_lo_n;
   wire lane_wr_w = !byte_write_gate_n && !(lane0_write_n && lane1_write_n);
   wire wr_w = !all_bytes_write_n || lane_wr_w;
   wire rd_load_w = !ctrl_addr_strobe_n && proc_addr_strobe_n && sel_w && !wr_w;
   wire step_rd_w = ctrl_addr_strobe_n && proc_addr_strobe_n && !burst_step_n && !wr_w;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);
   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_sleep_no_drive: assert property (sleep_request |-> !dev_dq_oe)
      else $error("data driven while asleep");
   chk_oe_gates_drive: assert property (oe_n |-> !dev_dq_oe)
      else $error("data driven with output enable off");
   chk_no_bus_fight: assert property (!(host_dq_oe && dev_dq_oe))
      else $error("both ends drive data");
   chk_lane_write_off: assert property (lane_wr_w |=> !dev_dq_oe)
      else $error("drive after lane write");
   chk_global_write_off: assert property (!all_bytes_write_n |=> !dev_dq_oe)
      else $error("drive after global write");
   chk_read_flow: assert property (rd_load_w ##1 !oe_n |-> dev_dq_oe)
      else $error("no flow-through read data");
   chk_burst_step: assert property (step_rd_w && dev_dq_oe ##1 !oe_n |-> dev_dq_oe)
      else $error("burst read beat missing");
   chk_ctrl_strobe: assert property (!ctrl_addr_strobe_n |-> proc_addr_strobe_n)
      else $error("controller start with processor strobe low");
   chk_sleep_quiet: assert property (sleep_request |-> ctrl_addr_strobe_n && proc_addr_strobe_n)
      else $error("strobe while asleep");
   chk_wake_quiet: assert property ($fell(sleep_request) |-> (ctrl_addr_strobe_n && all_bytes_write_n) [*8])
      else $error("transfer while waking");
   cov_read: cover property (rd_load_w);
   cov_lane: cover property (lane_wr_w);
   cov_sleep: cover property ($rose(sleep_request));
   cov_linear: cover property (!burst_order_sel && !ctrl_addr_strobe_n);
endmodule // fts_bus_properties

/* File: verification/tb_flow_through_burst_sram.sv */
`timescale 1ns/1ns
module tb_flow_through_burst_sram import fts_pkg::*; ();
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic [31:0] reg_rdata;
   logic burst_active, sleeping, read_mode;
   logic [17:0] mdl [logic [17:0]];
   int err_count = 0;
   int check_count = 0;
   fts_bus_if bus ();
   fts_sram_host i_fts_sram_host (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS(bus), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_we), .REG_RD(reg_re), .REG_RDATA(reg_rdata));
   fts_sram_dev i_fts_sram_dev (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS(bus), .BURST_ACTIVE(burst_active),
      .SLEEPING(sleeping), .READ_MODE(read_mode));
   fts_bus_properties i_fts_bus_properties (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
      .master_select_n(bus.master_select_n), .chip_sel_hi(bus.chip_sel_hi), .chip_sel_lo_n(bus.chip_sel_lo_n),
      .proc_addr_strobe_n(bus.proc_addr_strobe_n), .ctrl_addr_strobe_n(bus.ctrl_addr_strobe_n),
      .burst_step_n(bus.burst_step_n), .all_bytes_write_n(bus.all_bytes_write_n),
      .byte_write_gate_n(bus.byte_write_gate_n), .lane0_write_n(bus.lane0_write_n),
      .lane1_write_n(bus.lane1_write_n), .oe_n(bus.oe_n), .burst_order_sel(bus.burst_order_sel),
      .sleep_request(bus.sleep_request), .host_dq_oe(bus.host_dq_oe), .dev_dq_oe(bus.dev_dq_oe));
   always #2 ref_clk = ~ref_clk;
   // ----------------------------------------
   // checking and ending
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmp_word(input logic [17:0] got, input logic [17:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ----------------------------------------
   // register port and transfers
   // ----------------------------------------
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge ref_clk);
      reg_we <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge ref_clk);
      reg_re <= 1'b0;
      #1 d = reg_rdata;
   endtask
   function automatic logic [17:0] baddr(logic [17:0] a, logic [1:0] k, logic lin);
      return {a[17:2], lin ? a[1:0] + k : a[1:0] ^ k};
   endfunction
   // go, then wait for done under a bound; lane mask only on single writes
   task automatic xfer(input logic [17:0] a, input logic wr, input logic bst, input logic lin, input logic [1:0] m);
      logic [17:0] wd [4];
      logic [17:0] ad;
      logic [31:0] d;
      reg_write(FTS_REG_ADDR, 32'(a));
      for (int k = 0; k < 4 && wr; k++) begin
         wd[k] = 18'($urandom());
         reg_write(8'h10 + 8'(4 * k), 32'(wd[k]));
      end
      reg_write(FTS_REG_CTRL, 32'({m, lin, 1'b0, bst, wr, 1'b1}));
      for (int i = 0; i < 60; i++) begin
         reg_read(FTS_REG_STATUS, d);
         if (d[3] === 1'b1) break;
      end
      cmp_reg(d & 32'h0000_0008, 32'h0000_0008);
      for (int k = 0; k < (bst ? 4 : 1); k++) begin
         ad = baddr(a, 2'(k), lin);
         if (wr) begin
            case (m)
               2'h1: mdl[ad] = {mdl[ad][17:9], wd[k][8:0]};
               2'h2: mdl[ad] = {wd[k][17:9], mdl[ad][8:0]};
               default: mdl[ad] = wd[k];
            endcase
         end else begin
            reg_read(8'h10 + 8'(4 * k), d);
            cmp_word(d[17:0], mdl[ad]);
         end
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [17:0] a;
      logic lin;
      logic [31:0] st;
      void'($urandom(26));
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         a = 18'($urandom());
         lin = (i < 2) ? i[0] : 1'($urandom());
         if (i < 4) a[1:0] = 2'h3;
         xfer(a, 1'b1, 1'b1, lin, 2'h0);
         xfer(baddr(a, 2'(i), 1'b0), 1'b1, 1'b0, 1'b0, 2'(i % 4));
         xfer({a[17:2], 2'($urandom())}, 1'b0, 1'b1, ~lin, 2'h0);
         xfer(a, 1'b0, 1'b0, 1'b0, 2'h0);
      end
      // sleep level set, outputs off, data kept across wake
      reg_write(FTS_REG_CTRL, 32'h0000_0008);
      repeat (20) @(posedge ref_clk);
      #1;
      cmp_reg({28'h0, sleeping, bus.dev_dq_oe, burst_active, read_mode}, 32'h0000_0008);
      reg_read(FTS_REG_STATUS, st);
      cmp_reg(st & 32'h0000_0002, 32'h0000_0002);
      reg_write(FTS_REG_CTRL, 32'h0000_0000);
      repeat (30) @(posedge ref_clk);
      reg_read(FTS_REG_STATUS, st);
      cmp_reg(st & 32'h0000_0006, 32'h0000_0000);
      xfer(a, 1'b0, 1'b1, 1'b0, 2'h0);
      cmp_reg({30'h0, burst_active, read_mode}, 32'h0000_0003);
      reg_read(8'h40, st);
      cmp_reg(st, 32'h0000_0000);
      stop_test();
   end
   // run needs under a thousand cycles; this cuts a hang
   initial begin
      #200000;
      err_count++;
      stop_test();
   end
endmodule // tb_flow_through_burst_sram
